// *** pkg/drive_cfg_pkg.sv ***
// package: register map, field layout, rate tables for drive frequency configuration
package drive_cfg_pkg;

  // ==========================================================
  // register indices (byte address is index times four)
  localparam logic [9:0] IDX_STIM_CFG = 10'h01a;
  localparam logic [9:0] IDX_IMP_CFG  = 10'h020;
  localparam logic [9:0] IDX_GEN_CFG  = 10'h021;
  localparam logic [9:0] IDX_STATUS   = 10'h022;
  localparam logic [9:0] IDX_COMMAND  = 10'h023;

  // ==========================================================
  // field positions
  localparam int IMP_FREQ_LSB  = 8;
  localparam int IMP_MAG_LSB   = 4;
  localparam int IMP_AHPF_LSB  = 0;
  localparam int GEN_MCS_LSB   = 0;
  localparam int GEN_EN_BIT    = 2;
  localparam int CMD_RESYNC    = 0;
  localparam int ST_FREQ_LSB   = 0;
  localparam int ST_MAG_LSB    = 4;
  localparam int ST_REMAP_BIT  = 7;
  localparam int ST_DET_OK_BIT = 8;
  localparam int ST_PEND_BIT   = 9;

  // ==========================================================
  // reset values and masks
  localparam logic [23:0] STIM_CFG_RESET = 24'h000055;
  localparam logic [23:0] STIM_CFG_MASK  = 24'h8f70ff;
  localparam logic [3:0]  FREQ_RESET     = 4'h8;
  localparam logic [2:0]  MAG_DEFAULT    = 3'h0;
  localparam logic [1:0]  AHPF_RESET     = 2'h0;
  localparam logic [1:0]  MCS_RESET      = 2'h0;
  localparam logic [3:0]  FREQ_DET_LO    = 4'h1;
  localparam logic [3:0]  FREQ_DET_HI    = 4'h2;
  localparam int          FREQ_ROWS      = 11;

  // modulation rate in Hz, row = frequency code (codes 10..15 share row 10), column = clock select
  localparam logic [17:0] FREQ_TABLE [FREQ_ROWS][4] = '{
    '{18'h20000, 18'h1f400, 18'h1f400, 18'h1f380},
    '{18'h14000, 18'h13880, 18'h13880, 18'h14000},
    '{18'h0a000, 18'h09c40, 18'h09c40, 18'h0a000},
    '{18'h0471c, 18'h04574, 18'h04574, 18'h0471c},
    '{18'h02000, 18'h01f40, 18'h01f40, 18'h01f38},
    '{18'h01000, 18'h00fa0, 18'h00fa0, 18'h00f9c},
    '{18'h00800, 18'h007d0, 18'h007d0, 18'h007ce},
    '{18'h00400, 18'h003e8, 18'h003e8, 18'h003e7},
    '{18'h00200, 18'h001f4, 18'h001f4, 18'h001f4},
    '{18'h00100, 18'h000fa, 18'h000fa, 18'h000fa},
    '{18'h00080, 18'h0007d, 18'h0007d, 18'h0007d}};

  // highest accepted current magnitude code per frequency row
  localparam logic [2:0] MAG_LIMIT [FREQ_ROWS] = '{
    3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1};

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       detector_input_polarity;
    logic [2:0] rsv_a;
    logic       differentiator_disable;
    logic [2:0] gain;
    logic       rsv_b;
    logic       analog_out_bandwidth_limit;
    logic [1:0] analog_out_select;
    logic [3:0] rsv_c;
    logic [3:0] positive_threshold;
    logic [3:0] negative_threshold;
  } stim_cfg_t;

  typedef struct packed {
    logic [3:0] drive_frequency_code;
    logic [2:0] drive_current_magnitude;
    logic [1:0] shared_analog_highpass;
  } imp_cfg_t;

endpackage : drive_cfg_pkg

// *** rtl/impedance_drive_freq_config.sv ***
// impedance drive frequency/magnitude mapping and stimulus detector configuration
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: unsupported combinations act as default settings
// R2: code 0000 gives four times master clock
// R3: code 0001 gives 81920 or 80000 Hz
// R4: code 0010 gives 40960 or 40000 Hz
// R5: code 0011 gives 18204 or 17780 Hz
// R6: codes 0100-0111 divide master clock by 4-32
// R7: codes 1000/1001 give 512/256 or 500/250
// R8: codes 101x/11xx give 128 or 125 Hz
// R9: codes 0001/0010 accept every magnitude
// R10: code 0100 rejects magnitude 111
// R11: code 0101 accepts magnitudes 000 to 011
// R12: code 0110 accepts magnitudes 000 to 010
// R13: codes 1000/1001 accept magnitudes 000, 001
// R14: config writes may disturb combined output stream
// R15: resync command restores shared channel synchronisation
// R16: host sets shared highpass before detector use
// R17: detector config is 24-bit RW at 0x1A
// R18: detector config field layout, rest reserved
// R19: detector works only with codes 0001/0010
// R20: polarity bit selects inverted detector input
// R21: codes 0000/0011 accept every magnitude
// R22: codes 0111, 101x, 11xx accept 000, 001
module impedance_drive_freq_config
  import drive_cfg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic [17:0]            drive_freq_hz,
  output logic [3:0]             drive_frequency_code,
  output logic [2:0]             drive_current_magnitude,
  output logic                   impedance_channel_enable,
  output logic [1:0]             shared_analog_highpass,
  output var stim_cfg_t          stim_cfg,
  output logic                   detector_operable,
  output logic                   detector_invert,
  output logic                   stream_disturb,
  output logic                   resync_pulse
);

  // ==========================================================
  // bus decode
  logic [9:0]  word_idx;
  logic        hit_stim;
  logic        hit_imp;
  logic        hit_gen;
  logic        hit_stat;
  logic        hit_cmd;
  logic        mapped;
  logic        setup;
  logic        wr_done;
  logic [31:0] byte_mask;

  assign word_idx = 10'(paddr[ADDR_W-1:2]);
  assign hit_stim = (word_idx == IDX_STIM_CFG);
  assign hit_imp  = (word_idx == IDX_IMP_CFG);
  assign hit_gen  = (word_idx == IDX_GEN_CFG);
  assign hit_stat = (word_idx == IDX_STATUS);
  assign hit_cmd  = (word_idx == IDX_COMMAND);
  assign mapped   = hit_stim | hit_imp | hit_gen | hit_stat | hit_cmd;
  assign setup    = psel & ~penable;
  // zero wait states: every access completes at its first access edge
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_done  = psel & penable & pwrite & mapped;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ==========================================================
  // stored configuration
  logic [23:0] stim_q;
  imp_cfg_t    imp_q;
  logic [1:0]  mcs_q;
  logic        en_q;
  logic [31:0] imp_word;
  logic [31:0] imp_new;
  logic [31:0] stim_new;

  assign imp_word = {20'h0, imp_q.drive_frequency_code, 1'b0,
                     imp_q.drive_current_magnitude, 2'h0, imp_q.shared_analog_highpass};
  assign imp_new  = (imp_word & ~byte_mask) | (pwdata & byte_mask);
  assign stim_new = ({8'h0, stim_q} & ~byte_mask) | (pwdata & byte_mask);

  // R17: detector config storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stim_q <= STIM_CFG_RESET;
    end else if (wr_done && hit_stim) begin
      // R18: reserved bits never stored
      stim_q <= stim_new[23:0] & STIM_CFG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imp_q.drive_frequency_code    <= FREQ_RESET;
      imp_q.drive_current_magnitude <= MAG_DEFAULT;
      imp_q.shared_analog_highpass  <= AHPF_RESET;
    end else if (wr_done && hit_imp) begin
      imp_q.drive_frequency_code    <= imp_new[IMP_FREQ_LSB +: 4];
      imp_q.drive_current_magnitude <= imp_new[IMP_MAG_LSB +: 3];
      imp_q.shared_analog_highpass  <= imp_new[IMP_AHPF_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcs_q <= MCS_RESET;
      en_q  <= 1'b0;
    end else if (wr_done && hit_gen && pstrb[0]) begin
      mcs_q <= pwdata[GEN_MCS_LSB +: 2];
      en_q  <= pwdata[GEN_EN_BIT];
    end
  end

  // ==========================================================
  // effective settings
  logic [3:0]  row;
  logic [2:0]  eff_mag;
  logic        mag_bad;
  logic [17:0] freq_d;

  // R8: codes 101x/11xx share lowest row
  assign row = (imp_q.drive_frequency_code > 4'h9) ? 4'ha : imp_q.drive_frequency_code;

  // R9: per-code magnitude ceiling (R10, R11, R12, R13, R21, R22)
  assign mag_bad = imp_q.drive_current_magnitude > MAG_LIMIT[row];

  // R1: unsupported magnitude falls back to default
  assign eff_mag = mag_bad ? MAG_DEFAULT : imp_q.drive_current_magnitude;

  // R2: rate lookup per clock select (R3, R4, R5, R6, R7)
  assign freq_d = FREQ_TABLE[row][mcs_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_freq_hz           <= FREQ_TABLE[4'h8][MCS_RESET];
      drive_frequency_code    <= FREQ_RESET;
      drive_current_magnitude <= MAG_DEFAULT;
      detector_operable       <= 1'b0;
    end else begin
      drive_freq_hz           <= freq_d;
      drive_frequency_code    <= imp_q.drive_frequency_code;
      drive_current_magnitude <= eff_mag;
      // R19: detector only at the two offset rates
      detector_operable       <= (imp_q.drive_frequency_code == FREQ_DET_LO) ||
                                 (imp_q.drive_frequency_code == FREQ_DET_HI);
    end
  end

  // R16: highpass routed to shared front end even when channel disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_analog_highpass   <= AHPF_RESET;
      impedance_channel_enable <= 1'b0;
      stim_cfg                 <= stim_cfg_t'(STIM_CFG_RESET);
      detector_invert          <= 1'b0;
    end else begin
      shared_analog_highpass   <= imp_q.shared_analog_highpass;
      impedance_channel_enable <= en_q;
      stim_cfg                 <= stim_cfg_t'(stim_q);
      // R20: polarity bit drives input inversion
      detector_invert          <= stim_q[23];
    end
  end

  // ==========================================================
  // disturbance and resynchronisation
  logic cfg_write;
  logic resync_cmd;
  logic pend_q;

  assign cfg_write  = wr_done & (hit_imp | hit_stim);
  assign resync_cmd = wr_done & hit_cmd & pstrb[0] & pwdata[CMD_RESYNC];

  // R14: flag a possible stream break per impedance or detector config write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_disturb <= 1'b0;
    end else begin
      stream_disturb <= cfg_write;
    end
  end

  // R15: resync pulse clears pending state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_pulse <= 1'b0;
      pend_q       <= 1'b0;
    end else begin
      resync_pulse <= resync_cmd;
      // a write in the resync cycle keeps the flag: set beats clear
      if (cfg_write) begin
        pend_q <= 1'b1;
      end else if (resync_cmd) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  logic [31:0] rd_d;
  logic [31:0] imp_rd;

  // read back shows the magnitude actually applied; the frequency code reads back as written, even for 101x/11xx
  assign imp_rd = {20'h0, imp_q.drive_frequency_code, 1'b0, eff_mag, 2'h0,
                   imp_q.shared_analog_highpass};

  always_comb begin
    rd_d = 32'h0;
    if (hit_stim) begin
      rd_d = {8'h0, stim_q};
    end else if (hit_imp) begin
      rd_d = imp_rd;
    end else if (hit_gen) begin
      rd_d = {29'h0, en_q, mcs_q};
    end else if (hit_stat) begin
      rd_d[ST_FREQ_LSB +: 4] = imp_q.drive_frequency_code;
      rd_d[ST_MAG_LSB +: 3]  = eff_mag;
      rd_d[ST_REMAP_BIT]     = mag_bad;
      rd_d[ST_DET_OK_BIT]    = detector_operable;
      rd_d[ST_PEND_BIT]      = pend_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_imp_write_bad;
    wr_done && hit_imp && (pstrb[1:0] == 2'h3) &&
    (pwdata[IMP_MAG_LSB +: 3] > MAG_LIMIT[(pwdata[IMP_FREQ_LSB +: 4] > 4'h9) ? 4'ha :
                                          pwdata[IMP_FREQ_LSB +: 4]]);
  endsequence

  sequence s_stim_read;
    setup && !pwrite && hit_stim ##1 psel && penable;
  endsequence

  sequence s_resync;
    resync_cmd && !cfg_write;
  endsequence

  a_remap_bad_mag: assert property (s_imp_write_bad |-> ##2 drive_current_magnitude == 3'h0) // R1
    else $error("unsupported magnitude not mapped to off");

  a_fast_rate_top: assert property (
    imp_q.drive_frequency_code == 4'h0 && mcs_q == 2'h3 |=> drive_freq_hz == 18'h1f380) // R2
    else $error("code 0000 at select 11 wrong rate");

  a_offset_rate: assert property (
    imp_q.drive_frequency_code == 4'h1 |=> drive_freq_hz inside {18'h14000, 18'h13880}) // R3
    else $error("code 0001 wrong rate");

  a_lowest_rate: assert property (
    imp_q.drive_frequency_code[3] && |imp_q.drive_frequency_code[2:1]
    |=> drive_freq_hz == ($past(mcs_q) == 2'h0 ? 18'h00080 : 18'h0007d)) // R8
    else $error("lowest rate row wrong");

  a_mag_ceiling: assert property (
    (drive_frequency_code == 4'h5 -> drive_current_magnitude <= 3'h3) &&
    (drive_frequency_code == 4'h6 -> drive_current_magnitude <= 3'h2) &&
    (drive_frequency_code == 4'h4 -> drive_current_magnitude != 3'h7)) // R11
    else $error("magnitude above allowed ceiling applied");

  a_detector_gate: assert property (
    detector_operable == (drive_frequency_code inside {4'h1, 4'h2})) // R19
    else $error("detector gate mismatch");

  a_stream_flag: assert property (cfg_write |=> stream_disturb) // R14
    else $error("config write without disturbance flag");

  a_resync_clear: assert property (s_resync |=> resync_pulse && !pend_q ##1 !resync_pulse) // R15
    else $error("resync did not pulse once and clear");

  a_stim_readback: assert property (s_stim_read |-> prdata == {8'h0, stim_q}
                                    && (prdata & ~{8'h0, STIM_CFG_MASK}) == 32'h0) // R18
    else $error("detector config read back wrong");

  a_polarity_out: assert property (##1 detector_invert == $past(stim_q[23])) // R20
    else $error("polarity not forwarded");

endmodule : impedance_drive_freq_config

`default_nettype wire

// *** verification/tb.sv ***
// testbench: register access, rate table and magnitude remap checks for the drive config block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import drive_cfg_pkg::*;
  // ==========================================================
  // signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [17:0] drive_freq_hz;
  logic [3:0]  drive_frequency_code;
  logic [2:0]  drive_current_magnitude;
  logic        impedance_channel_enable;
  logic [1:0]  shared_analog_highpass;
  stim_cfg_t   stim_cfg;
  logic        detector_operable;
  logic        detector_invert;
  logic        stream_disturb;
  logic        resync_pulse;
  int          errors;
  int          total_checks;
  int          sd_cnt;
  int          rs_cnt;
  logic [31:0] d;
  logic        e;
  // expected rates, row = code (codes 10..15 share the last row), column = clock select
  localparam int rate_exp [11][4] = '{
    '{131072, 128000, 128000, 127872}, '{81920, 80000, 80000, 81920},
    '{40960, 40000, 40000, 40960}, '{18204, 17780, 17780, 18204},
    '{8192, 8000, 8000, 7992}, '{4096, 4000, 4000, 3996},
    '{2048, 2000, 2000, 1998}, '{1024, 1000, 1000, 999},
    '{512, 500, 500, 500}, '{256, 250, 250, 250}, '{128, 125, 125, 125}};
  localparam int mag_max [11] = '{7, 7, 7, 7, 6, 3, 2, 1, 1, 1, 1};

  impedance_drive_freq_config dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .pready                   (pready),
    .prdata                   (prdata),
    .pslverr                  (pslverr),
    .drive_freq_hz            (drive_freq_hz),
    .drive_frequency_code     (drive_frequency_code),
    .drive_current_magnitude  (drive_current_magnitude),
    .impedance_channel_enable (impedance_channel_enable),
    .shared_analog_highpass   (shared_analog_highpass),
    .stim_cfg                 (stim_cfg),
    .detector_operable        (detector_operable),
    .detector_invert          (detector_invert),
    .stream_disturb           (stream_disturb),
    .resync_pulse             (resync_pulse)
  );

  // ==========================================================
  // clock and pulse counters
  always #5 pclk = ~pclk;

  // counting cycles makes the pulse check independent of its exact launch edge
  always @(posedge pclk) begin
    if (stream_disturb === 1'b1) sd_cnt++;
    if (resync_pulse === 1'b1) rs_cnt++;
  end

  // ==========================================================
  // tasks
  task automatic final_report();
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // write, then let the registered outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
    apb(a, 1'b1, wd, s, d, e);
    repeat (3) @(posedge pclk);
    #1;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, 4'hf, d, e);
    chk(d, exp);
  endtask : rdc

  // ==========================================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    errors = 0;
    total_checks = 0;
    sd_cnt = 0;
    rs_cnt = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(drive_freq_hz), 32'h200);
    rdc(12'h068, 32'h000055);
    wr(12'h068, 32'h00aaaaff, 4'h1);
    rdc(12'h068, 32'h0000ff);
    sd_cnt = 0;
    wr(12'h068, 32'hffffffff, 4'hf);
    chk(32'(sd_cnt), 32'h1);
    rdc(12'h068, 32'h8f70ff);
    chk(32'(stim_cfg), 32'h8f70ff);
    chk(32'(detector_invert), 32'h1);
    wr(12'h068, 32'h0, 4'hf);
    chk(32'(detector_invert), 32'h0);
    apb(12'h100, 1'b0, 32'h0, 4'hf, d, e);
    chk(d, 32'h0);
    chk(32'(e), 32'h1);
    // odd clock selects enable the channel, even ones leave it off: highpass must follow anyway
    for (int m = 0; m < 4; m++) begin
      wr(12'h084, 32'(((m & 1) << 2) | m), 4'h1);
      chk(32'(impedance_channel_enable), 32'(m & 1));
      for (int c = 0; c < 16; c++) begin
        for (int g = 0; g < 8; g++) begin
          int r;
          r = (c > 10) ? 10 : c;
          wr(12'h080, 32'((c << 8) | (g << 4) | m), 4'hf);
          chk(32'(drive_frequency_code), 32'(c));
          chk(32'(drive_freq_hz), 32'(rate_exp[r][m]));
          chk(32'(drive_current_magnitude), 32'((g <= mag_max[r]) ? g : 0));
          chk(32'(detector_operable), 32'((c == 1) || (c == 2)));
          chk(32'(shared_analog_highpass), 32'(m));
        end
      end
    end
    // last setting left code 1111 with magnitude 111, so remapped and pending
    rdc(12'h088, 32'h28f);
    // impedance config reads back the applied magnitude, not the written one
    rdc(12'h080, 32'hf03);
    rdc(12'h084, 32'h7);
    rs_cnt = 0;
    wr(12'h08c, 32'h1, 4'hf);
    chk(32'(rs_cnt), 32'h1);
    rdc(12'h088, 32'h08f);
    wr(12'h08c, 32'h0, 4'hf);
    chk(32'(rs_cnt), 32'h1);
    rdc(12'h08c, 32'h0);
    final_report();
  end
endmodule : tb
`default_nettype wire
